//--- rtl/clk_port_cfg.svh
// Constants for the clock synthesizer control port and output routing
`ifndef CLK_PORT_CFG_SVH
`define CLK_PORT_CFG_SVH
// Register pointer values
`define REG_ID        7'h01
`define REG_CTRL      7'h02
`define REG_CFG1      7'h03
`define REG_GLOB      7'h05
`define REG_RATIO_B3  7'h06
`define REG_RATIO_B2  7'h07
`define REG_RATIO_B1  7'h08
`define REG_RATIO_B0  7'h09
`define REG_FUNC1     7'h16
`define REG_FUNC2     7'h17
// Field positions
`define CTRL_UNLOCK   7
`define CTRL_AUX_DIS  1
`define CTRL_CLK_DIS  0
`define CFG1_RMOD_HI  7
`define CFG1_RMOD_LO  5
`define CFG1_AUX_HI   2
`define CFG1_AUX_LO   1
`define CFG1_EN1      0
`define GLOB_EN2      0
`define FUNC1_LOCKCFG 6
`define FUNC1_DIV_HI  4
`define FUNC1_DIV_LO  3
`define FUNC2_UNL     4
`define PTR_INC       7
// Reset value of every writable register
`define REG_RST       8'h00
// Chip addresses
`define SPI_CHIP_ADDR 8'h9e
`define I2C_ADDR_HI   6'h27
// Auxiliary source codes
`define AUX_REF       2'h0
`define AUX_PLL       2'h2
`define AUX_LOCK      2'h3
// Reference divider code that means no division
`define DIV_NONE      2'h3
// Synchroniser lane positions
`define P_SCL  0
`define P_SDA  1
`define P_SEL  2
`define P_REF  3
`define P_PLL  4
`define P_LOCK 5
// Reference gap that counts as a discontinuity
`define CLK_PERIOD_NS 20
`define REF_GAP_NS    1000
`define REF_GAP_CYC   (`REF_GAP_NS / `CLK_PERIOD_NS)
`endif

//--- rtl/clk_port_pkg.sv
// Types for the clock synthesizer control port
`default_nettype none
package clk_port_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_DATA, ST_ACK, ST_READ, ST_IGNORE} port_state_t;
    typedef struct packed {
        logic pin;  // Pin level
        logic oe;   // Driver enabled
    } pin_drive_t;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  cfg1;
        logic [7:0]  glob;
        logic [31:0] user_ratio;
        logic [7:0]  func1;
        logic [7:0]  func2;
    } regs_t;
    typedef struct packed {
        logic [5:0]  sync1;
        logic [5:0]  sync2;
        logic [5:0]  prev;
        logic        spi_mode;
        port_state_t state;
        port_state_t after_ack;
        logic        ack_driven;
        logic [3:0]  cnt;
        logic [7:0]  shift;
        logic [6:0]  ptr;
        logic        autoinc;
        logic        sda_oe;
        regs_t       regs;
        logic        unlocked;
        logic [7:0]  ref_gap;
        logic        restart;
        logic        clk_gate;
        logic        clk_en;
        logic [1:0]  aux_src;
        logic        aux_en;
        pin_drive_t  clk_pin;
        pin_drive_t  aux_pin;
        logic [31:0] eff_ratio;
    } port_st_t;
endpackage
`default_nettype wire

//--- rtl/clk_port.sv
// Control port, register file and glitch-free output routing of a clock synthesizer
`include "clk_port_cfg.svh"
`default_nettype none
// Behaviour
// - Unlocked PLL forces clock output low unless pll_out_on_unlock is set.
// - pll_out_disable puts the clock output driver in high impedance.
// - aux_source_select 00 reference, 10 PLL clock, 11 lock; 01 reserved.
// - lock_output_config picks driver type and polarity of the lock indicator.
// - aux_out_disable puts the auxiliary driver in high impedance.
// - Enables, 00/10 switches and unlock gating never cut a clock period short.
// - Lock-source switches may glitch; pll_out_on_unlock changes apply only while the PLL clock is low.
// - Fractional-N register changes or reference gaps force the PLL unlocked.
// - Effective ratio is user ratio shifted by modifier, corrected for divider.
// - A falling edge on the select pin enters SPI mode; otherwise I2C.
// - SPI data sampled on rising bit clock; writes only.
// - SPI write: address 10011110, pointer byte, then data bytes, MSB first.
// - With auto-increment the pointer advances after every data byte.
// - Pointer byte MSB is auto-increment; lower bits select the register.
// - SDA fall with SCL high is Start, rise is Stop.
// - I2C address 100111 plus address pin level, then direction bit.
// - I2C write loads pointer first, then stores following data bytes.
// - Device acknowledges received bytes; host acknowledges sent bytes.
// - Port logic needs no timing relation to the reference or PLL clocks.
module clk_port #(
    parameter logic [7:0] ID_CODE = 8'h5a  // Identification byte, value arbitrary
) (
    input  wire logic                       clk_in,            // System clock, 50 MHz
    input  wire logic                       rst_in,            // Synchronous reset, active high
    input  wire logic                       ser_clk_in,        // SCL or SPI bit clock
    input  wire logic                       ser_data_in,       // SDA level or serial_data_in
    output var  logic                       ser_data_out,      // SDA output level, always low
    output var  logic                       ser_data_oe_out,   // SDA pulled low when high
    input  wire logic                       address_or_select_pin_in, // Address bit or chip select
    input  wire logic                       timing_reference_in,      // Reference clock
    input  wire logic                       pll_clk_in,        // Synthesizer output clock
    input  wire logic                       pll_lock_in,       // Analog lock detect
    output var  clk_port_pkg::pin_drive_t   clk_pin_out,       // PLL clock pin and driver enable
    output var  clk_port_pkg::pin_drive_t   aux_pin_out,       // Auxiliary pin and driver enable
    output var  logic [31:0]                effective_ratio_out, // Ratio for the synthesizer
    output var  logic                       pll_restart_out    // One-cycle unlock request
);
    import clk_port_pkg::*;

    // ----------------------------------------
    // Register access helpers
    // ----------------------------------------
    function automatic regs_t reg_write(input regs_t r, input logic [6:0] p, input logic [7:0] d);
        regs_t w;
        w = r;
        case (p)
            `REG_CTRL:     w.ctrl = {1'b0, 5'h00, d[`CTRL_AUX_DIS:`CTRL_CLK_DIS]};
            `REG_CFG1:     w.cfg1 = d;
            `REG_GLOB:     w.glob = d;
            `REG_RATIO_B3: w.user_ratio[31:24] = d;
            `REG_RATIO_B2: w.user_ratio[23:16] = d;
            `REG_RATIO_B1: w.user_ratio[15:8] = d;
            `REG_RATIO_B0: w.user_ratio[7:0] = d;
            `REG_FUNC1:    w.func1 = d;
            `REG_FUNC2:    w.func2 = d;
            default:       w = r;
        endcase
        return w;
    endfunction

    function automatic logic [7:0] reg_read(input regs_t r, input logic [6:0] p, input logic unl);
        logic [7:0] v;
        v = 8'h00;
        case (p)
            `REG_ID:       v = ID_CODE;
            `REG_CTRL:     v = {unl, r.ctrl[6:0]};
            `REG_CFG1:     v = r.cfg1;
            `REG_GLOB:     v = r.glob;
            `REG_RATIO_B3: v = r.user_ratio[31:24];
            `REG_RATIO_B2: v = r.user_ratio[23:16];
            `REG_RATIO_B1: v = r.user_ratio[15:8];
            `REG_RATIO_B0: v = r.user_ratio[7:0];
            `REG_FUNC1:    v = r.func1;
            `REG_FUNC2:    v = r.func2;
            default:       v = 8'h00;
        endcase
        return v;
    endfunction

    port_st_t   st_reg;
    port_st_t   st_next;

    // ----------------------------------------
    // Synchronised pin levels and edges
    // ----------------------------------------
    logic        scl;
    logic        sda;
    logic        sel;
    logic        scl_rise;
    logic        scl_fall;
    logic        sda_rise;
    logic        sda_fall;
    logic        sel_fall;
    logic        ref_s;
    logic        pll_s;
    logic        lock_s;
    logic [7:0]  in_byte;
    logic        i2c_start;
    logic        i2c_stop;
    logic [2:0]  rmod;
    logic [1:0]  rdiv;
    logic [1:0]  aux_want;
    logic        clk_want;
    logic        aux_val;
    logic [31:0] ratio_mod;

    // async pins cross two flops; only stage two feeds logic
    assign scl       = st_reg.sync2[`P_SCL];
    assign sda       = st_reg.sync2[`P_SDA];
    assign sel       = st_reg.sync2[`P_SEL];
    assign ref_s     = st_reg.sync2[`P_REF];
    assign pll_s     = st_reg.sync2[`P_PLL];
    assign lock_s    = st_reg.sync2[`P_LOCK];
    assign scl_rise  = scl & ~st_reg.prev[`P_SCL];
    assign scl_fall  = ~scl & st_reg.prev[`P_SCL];
    assign sda_rise  = sda & ~st_reg.prev[`P_SDA];
    assign sda_fall  = ~sda & st_reg.prev[`P_SDA];
    assign sel_fall  = ~sel & st_reg.prev[`P_SEL];
    assign in_byte   = {st_reg.shift[6:0], sda};
    assign i2c_start = ~st_reg.spi_mode & scl & st_reg.prev[`P_SCL] & sda_fall;
    assign i2c_stop  = ~st_reg.spi_mode & scl & st_reg.prev[`P_SCL] & sda_rise;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        st_next         = st_reg;
        st_next.sync1   = {pll_lock_in, pll_clk_in, timing_reference_in,
                           address_or_select_pin_in, ser_data_in, ser_clk_in};
        st_next.sync2   = st_reg.sync1;
        st_next.prev    = st_reg.sync2;
        st_next.restart = 1'b0;

        // select pin falling edge latches SPI mode
        if (sel_fall)
        begin
            st_next.spi_mode = 1'b1;
        end

        // Serial protocol; frame boundaries win over bit activity
        if (st_reg.spi_mode && sel)
        begin
            st_next.state = ST_IDLE;
        end
        else if (sel_fall || i2c_start)
        begin
            st_next.state  = ST_ADDR;
            st_next.cnt    = 4'h0;
            st_next.sda_oe = 1'b0;
        end
        else if (i2c_stop)
        begin
            st_next.state  = ST_IDLE;
            st_next.sda_oe = 1'b0;
        end
        else
        begin
            case (st_reg.state)
                ST_ADDR, ST_PTR, ST_DATA:
                begin
                    // bits taken on the rising bit clock, MSB first
                    if (scl_rise)
                    begin
                        st_next.shift = in_byte;
                        st_next.cnt   = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == 4'h7)
                        begin
                            st_next.cnt       = 4'h0;
                            st_next.after_ack = ST_DATA;
                            st_next.state     = st_reg.spi_mode ? ST_DATA : ST_ACK;
                            if (st_reg.state == ST_ADDR)
                            begin
                                // mismatch ignores the rest of the frame
                                if (st_reg.spi_mode)
                                begin
                                    st_next.state = (in_byte == `SPI_CHIP_ADDR) ? ST_PTR : ST_IGNORE;
                                end
                                // I2C address with pin level as LSB
                                else if (in_byte[7:1] == {`I2C_ADDR_HI, sel})
                                begin
                                    st_next.after_ack = in_byte[0] ? ST_READ : ST_PTR;
                                end
                                else
                                begin
                                    st_next.state = ST_IDLE;
                                end
                            end
                            else if (st_reg.state == ST_PTR)
                            begin
                                st_next.ptr     = in_byte[6:0];
                                st_next.autoinc = in_byte[`PTR_INC];
                            end
                            else
                            begin
                                // store data byte at the pointer
                                st_next.regs = reg_write(st_reg.regs, st_reg.ptr, in_byte);
                                if (st_reg.autoinc)
                                begin
                                    st_next.ptr = st_reg.ptr + 7'h01;
                                end
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    // drive acknowledge for one SCL low-high-low period
                    if (scl_fall)
                    begin
                        st_next.ack_driven = ~st_reg.ack_driven;
                        st_next.sda_oe     = ~st_reg.ack_driven;
                        if (st_reg.ack_driven)
                        begin
                            st_next.state = st_reg.after_ack;
                            if (st_reg.after_ack == ST_READ)
                            begin
                                st_next.shift  = reg_read(st_reg.regs, st_reg.ptr, st_reg.unlocked);
                                st_next.sda_oe = ~st_next.shift[7];
                            end
                        end
                    end
                end
                ST_READ:
                begin
                    // Drive read data on falling SCL, release for host acknowledge
                    if (scl_fall)
                    begin
                        st_next.sda_oe = (st_reg.cnt < 4'h8) ? ~st_reg.shift[3'h7 - st_reg.cnt[2:0]] : 1'b0;
                    end
                    if (scl_rise)
                    begin
                        if (st_reg.cnt < 4'h8)
                        begin
                            st_next.cnt = st_reg.cnt + 4'h1;
                            if (st_reg.cnt == 4'h7 && st_reg.autoinc)
                            begin
                                st_next.ptr = st_reg.ptr + 7'h01;
                            end
                        end
                        // host acknowledge continues, no acknowledge ends the read
                        else if (!sda)
                        begin
                            st_next.cnt   = 4'h0;
                            st_next.shift = reg_read(st_reg.regs, st_reg.ptr, st_reg.unlocked);
                        end
                        else
                        begin
                            st_next.state = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    st_next.state = st_reg.state;
                end
            endcase
        end

        // fractional-N settings changed by a write
        if ((st_next.regs.user_ratio != st_reg.regs.user_ratio)
            || (st_next.regs.cfg1[`CFG1_RMOD_HI:`CFG1_RMOD_LO] != st_reg.regs.cfg1[`CFG1_RMOD_HI:`CFG1_RMOD_LO])
            || (st_next.regs.func1[`FUNC1_DIV_HI:`FUNC1_DIV_LO] != st_reg.regs.func1[`FUNC1_DIV_HI:`FUNC1_DIV_LO]))
        begin
            st_next.restart = 1'b1;
        end
        st_next.ref_gap = (ref_s != st_reg.prev[`P_REF]) ? 8'h00 : st_reg.ref_gap + 8'h01;
        if (st_reg.ref_gap == 8'(`REF_GAP_CYC))
        begin
            st_next.restart = 1'b1;
            st_next.ref_gap = 8'h00;
        end
        // Unlocked until the lock detect rises after a restart; the set wins
        if (st_next.restart || !lock_s)
        begin
            st_next.unlocked = 1'b1;
        end
        else if (!st_reg.prev[`P_LOCK])
        begin
            st_next.unlocked = 1'b0;
        end

        rmod      = st_reg.regs.cfg1[`CFG1_RMOD_HI:`CFG1_RMOD_LO];
        rdiv      = st_reg.regs.func1[`FUNC1_DIV_HI:`FUNC1_DIV_LO];
        ratio_mod = rmod[2] ? (st_reg.regs.user_ratio >> ({1'b0, rmod[1:0]} + 3'h1))
                            : (st_reg.regs.user_ratio << rmod[1:0]);
        st_next.eff_ratio = (rdiv == `DIV_NONE) ? ratio_mod : (ratio_mod << rdiv);

        // gate the PLL clock while unlocked unless told otherwise
        clk_want = st_reg.regs.cfg1[`CFG1_EN1] & st_reg.regs.glob[`GLOB_EN2]
                   & (~st_reg.unlocked | st_reg.regs.func2[`FUNC2_UNL]);
        // gate and driver enable change only while the PLL clock is low
        if (!pll_s)
        begin
            st_next.clk_gate = clk_want;
            // driver off when pll_out_disable is set
            st_next.clk_en   = ~st_reg.regs.ctrl[`CTRL_CLK_DIS];
        end
        st_next.clk_pin.pin = pll_s & st_reg.clk_gate;
        st_next.clk_pin.oe  = st_reg.clk_en;

        // auxiliary source select, reserved code keeps the current source
        aux_want = st_reg.regs.cfg1[`CFG1_AUX_HI:`CFG1_AUX_LO];
        if (aux_want == `AUX_REF || aux_want == `AUX_PLL || aux_want == `AUX_LOCK)
        begin
            // clock-to-clock switch waits for both clocks low
            // switches to or from the lock source take effect at once
            if ((aux_want == `AUX_LOCK) || (st_reg.aux_src == `AUX_LOCK) || (!ref_s && !st_next.clk_pin.pin))
            begin
                st_next.aux_src = aux_want;
            end
        end
        case (st_reg.aux_src)
            `AUX_REF: aux_val = ref_s;
            `AUX_PLL: aux_val = st_reg.clk_pin.pin;
            default:  aux_val = st_reg.regs.func1[`FUNC1_LOCKCFG] ? st_reg.unlocked : ~st_reg.unlocked;
        endcase
        // aux driver enable, changed only while the output is low or the lock source is selected
        if (!aux_val || st_reg.aux_src == `AUX_LOCK)
        begin
            st_next.aux_en = ~st_reg.regs.ctrl[`CTRL_AUX_DIS];
        end
        st_next.aux_pin.pin = aux_val;
        // lock config 1 gives an open-drain, active-low lock flag
        if (st_reg.aux_src == `AUX_LOCK && st_reg.regs.func1[`FUNC1_LOCKCFG])
        begin
            st_next.aux_pin.pin = 1'b0;
            st_next.aux_pin.oe  = st_reg.aux_en & ~st_reg.unlocked;
        end
        else
        begin
            st_next.aux_pin.oe = st_reg.aux_en;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_reg            <= '0;
            st_reg.state      <= ST_IDLE;
            st_reg.after_ack  <= ST_IDLE;
            st_reg.regs.ctrl  <= `REG_RST;
            st_reg.regs.cfg1  <= `REG_RST;
            st_reg.regs.glob  <= `REG_RST;
            st_reg.regs.func1 <= `REG_RST;
            st_reg.regs.func2 <= `REG_RST;
            st_reg.unlocked   <= 1'b1;
            ser_data_out      <= 1'b0;
        end
        else
        begin
            st_reg       <= st_next;
            ser_data_out <= 1'b0;
        end
    end

    // Outputs straight from the state register
    assign ser_data_oe_out     = st_reg.sda_oe;
    assign clk_pin_out         = st_reg.clk_pin;
    assign aux_pin_out         = st_reg.aux_pin;
    assign effective_ratio_out = st_reg.eff_ratio;
    assign pll_restart_out     = st_reg.restart;
endmodule // clk_port
`default_nettype wire

//--- verif/clk_port_properties.sv
// Checks on the control port pins
`default_nettype none
module clk_port_properties (
    input wire logic                     clk_in,              // Clock
    input wire logic                     rst_in,              // Reset
    input wire logic                     ser_clk_in,          // SCL
    input wire logic                     ser_data_oe_out,     // SDA pull
    input wire logic                     timing_reference_in, // Reference
    input wire logic                     pll_clk_in,          // PLL clock
    input wire clk_port_pkg::pin_drive_t clk_pin_out,         // Clock pin
    input wire logic [31:0]              effective_ratio_out, // Ratio
    input wire logic                     pll_restart_out      // Relock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ref_cnt; // Reference idle cycles
    logic       ref_q;   // Reference one cycle ago
    // Reference stall counter
    always_ff @(posedge clk_in)
    begin
        ref_q <= timing_reference_in;
        if (rst_in || timing_reference_in != ref_q)
            ref_cnt <= 8'h00;
        else if (ref_cnt != 8'hff)
            ref_cnt <= ref_cnt + 8'h01;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_CLK_RISE: assert property ($rose(clk_pin_out.pin) |-> $past(pll_clk_in))
        else $error("clock pin rose early");
    AST_CLK_HIGH: assert property ($rose(clk_pin_out.pin) |-> clk_pin_out.pin [*8])
        else $error("short high clock");
    AST_CLK_LOW: assert property ($fell(clk_pin_out.pin) |-> !clk_pin_out.pin [*8])
        else $error("short low clock");
    AST_CLK_OE: assert property ($changed(clk_pin_out.oe) |-> !clk_pin_out.pin)
        else $error("oe moved with pin high");
    AST_RESTART_ONE: assert property (pll_restart_out |=> !pll_restart_out)
        else $error("relock too long");
    AST_RATIO_RESTART: assert property ($changed(effective_ratio_out) |->
        ##[0:2] pll_restart_out or $past(pll_restart_out) || $past(pll_restart_out, 2))
        else $error("ratio changed without relock");
    AST_REF_GAP: assert property (ref_cnt == 8'h31 |-> ##[0:8] pll_restart_out)
        else $error("no relock on stall");
    AST_ACK_EDGE: assert property ($changed(ser_data_oe_out) |-> !$past(ser_clk_in) && !$past(ser_clk_in, 2))
        else $error("SDA moved with SCL high");
    AST_ACK_HOLD: assert property ($rose(ser_data_oe_out) |-> ser_data_oe_out [*8])
        else $error("acknowledge too short");
endmodule // clk_port_properties
bind clk_port clk_port_properties i_clk_port_properties (.*);
`default_nettype wire

//--- verif/clk_port_host.sv
// Host model on the serial pins
`default_nettype none
module clk_port_host (
    input  wire logic clk_in,      // Clock
    input  wire logic sda_in,      // SDA wire
    output var  logic scl_out,     // Serial clock
    output var  logic sda_low_out, // Pulls SDA low
    output var  logic sel_out      // Address bit or select
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {scl_out, sda_low_out, sel_out} = 3'b101;
    task automatic hp(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic start();
        sda_low_out <= 1'b1;
        hp(10);
        scl_out <= 1'b0;
        hp(5);
    endtask
    task automatic stop();
        sda_low_out <= 1'b1;
        hp(5);
        scl_out <= 1'b1;
        hp(10);
        sda_low_out <= 1'b0;
        hp(10);
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low_out <= ~d[i];
            hp(5);
            scl_out <= 1'b1;
            hp(10);
            q[i] = sda_in;
            scl_out <= 1'b0;
            hp(5);
        end
    endtask
    task automatic spi(input logic [23:0] w);
        sel_out <= 1'b0;
        scl_out <= 1'b0;
        hp(10);
        for (int i = 23; i >= 0; i--)
        begin
            sda_low_out <= ~w[i];
            hp(10);
            scl_out <= 1'b1;
            hp(10);
            scl_out <= 1'b0;
        end
        hp(10);
        sel_out <= 1'b1;
        sda_low_out <= 1'b0;
        hp(10);
    endtask
endmodule // clk_port_host
`default_nettype wire

//--- verif/clk_port_test.sv
// Bench for the control port
`include "clk_port_cfg.svh"
`default_nettype none
module clk_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_port_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, ref_in = 1'b0, pll_in = 1'b0, lock_in = 1'b1, ref_run = 1'b1;
    logic scl, sda_low, sel, sda_oe, sda_dout, restart;
    wire logic sda = !(sda_low | (sda_oe & !sda_dout));
    pin_drive_t clk_pin, aux_pin;
    logic [31:0] ratio;
    logic [8:0] q;
    int fails = 0, samples_checked = 0, cnt = 0, restarts = 0;
    always #10 clk_in = ~clk_in;
    // Slow clocks and relock count
    always @(posedge clk_in)
    begin
        cnt <= cnt + 1;
        if (ref_run && cnt % 15 == 0) ref_in <= ~ref_in;
        if (cnt % 25 == 0) pll_in <= ~pll_in;
        if (restart === 1'b1) restarts <= restarts + 1;
    end
    clk_port i_clk_port (.clk_in(clk_in), .rst_in(rst_in), .ser_clk_in(scl), .ser_data_in(sda),
        .ser_data_out(sda_dout), .ser_data_oe_out(sda_oe), .address_or_select_pin_in(sel),
        .timing_reference_in(ref_in), .pll_clk_in(pll_in), .pll_lock_in(lock_in),
        .clk_pin_out(clk_pin), .aux_pin_out(aux_pin), .effective_ratio_out(ratio), .pll_restart_out(restart));
    clk_port_host i_clk_port_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low),
        .sel_out(sel));
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic inc, input logic [6:0] p, input logic [31:0] d, input int n);
        i_clk_port_host.start();
        i_clk_port_host.xfer({`I2C_ADDR_HI, 3'b101}, q);
        ck(32'(q[0]), 32'h0);
        i_clk_port_host.xfer({inc, p, 1'b1}, q);
        ck(32'(q[0]), 32'h0);
        for (int i = n - 1; i >= 0; i--)
        begin
            i_clk_port_host.xfer({d[8*i+:8], 1'b1}, q);
            ck(32'(q[0]), 32'h0);
        end
        i_clk_port_host.stop();
        repeat (20) @(posedge clk_in);
    endtask
    task automatic rd(input logic [6:0] p, input logic [7:0] e);
        wr(1'b0, p, 32'h0, 0);
        i_clk_port_host.start();
        i_clk_port_host.xfer({`I2C_ADDR_HI, 3'b111}, q);
        i_clk_port_host.xfer(9'h1ff, q);
        ck(32'(q[8:1]), 32'(e));
        i_clk_port_host.stop();
    endtask
    task automatic watch(output logic c, output logic a);
        {c, a} = 2'b00;
        repeat (100)
        begin
            @(posedge clk_in);
            c |= clk_pin.pin;
            a |= aux_pin.pin;
        end
    endtask
    task automatic t_regs();
        rd(`REG_CFG1, `REG_RST);
        wr(1'b0, `REG_CFG1, 32'h01, 1);
        wr(1'b0, `REG_GLOB, 32'h01, 1);
        rd(`REG_CFG1, 8'h01);
        i_clk_port_host.start();
        i_clk_port_host.xfer({`I2C_ADDR_HI, 3'b001}, q);
        ck(32'(q[0]), 32'h1);
        i_clk_port_host.stop();
        $display("t_regs done");
    endtask
    task automatic t_ratio();
        wr(1'b1, `REG_RATIO_B3, 32'h00123456, 4);
        ck(ratio, 32'h00123456);
        wr(1'b0, `REG_RATIO_B3, 32'h0102, 2);
        ck(ratio, 32'h02123456);
        wr(1'b0, `REG_CFG1, 32'h21, 1);
        ck(ratio, 32'h042468ac);
        wr(1'b0, `REG_FUNC1, 32'h08, 1);
        ck(ratio, 32'h0848d158);
        ck(32'(restarts > 3), 32'h1);
        $display("t_ratio done");
    endtask
    task automatic t_out();
        logic c, a;
        lock_in <= 1'b0;
        repeat (50) @(posedge clk_in);
        watch(c, a);
        ck(32'(c), 32'h0);
        lock_in <= 1'b1;
        watch(c, a);
        ck(32'({c, a, clk_pin.oe}), 32'h7);
        wr(1'b0, `REG_CTRL, 32'h01, 1);
        ck(32'(clk_pin.oe), 32'h0);
        wr(1'b0, `REG_CTRL, 32'h02, 1);
        ck(32'({clk_pin.oe, aux_pin.oe}), 32'h2);
        wr(1'b0, `REG_CTRL, 32'h00, 1);
        wr(1'b0, `REG_CFG1, 32'h25, 1);
        watch(c, a);
        ck(32'(a), 32'h1);
        wr(1'b0, `REG_CFG1, 32'h27, 1);
        ck(32'(aux_pin), 32'h3);
        wr(1'b0, `REG_FUNC1, 32'h48, 1);
        ck(32'(aux_pin), 32'h1);
        lock_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        ck(32'(aux_pin.oe), 32'h0);
        lock_in <= 1'b1;
        $display("t_out done");
    endtask
    task automatic t_gap();
        int r = restarts;
        ref_run <= 1'b0;
        repeat (80) @(posedge clk_in);
        ck(32'(restarts > r), 32'h1);
        ref_run <= 1'b1;
        $display("t_gap done");
    endtask
    task automatic t_spi();
        i_clk_port_host.spi({`SPI_CHIP_ADDR, 1'b0, `REG_CTRL, 8'h01});
        repeat (60) @(posedge clk_in);
        ck(32'(clk_pin.oe), 32'h0);
        i_clk_port_host.spi({8'h9f, 1'b0, `REG_CTRL, 8'h00});
        repeat (60) @(posedge clk_in);
        ck(32'({clk_pin.oe, sda_oe}), 32'h0);
        $display("t_spi done");
    endtask
    task automatic finish_test();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Test sequence
    initial
    begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        t_regs();
        t_ratio();
        t_out();
        t_gap();
        t_spi();
        finish_test();
    end
    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk_in);
        fails++;
        finish_test();
    end
endmodule // clk_port_test
`default_nettype wire
